// ===== stc_consts.svh
`ifndef STC_CONSTS_SVH
`define STC_CONSTS_SVH
`define STC_OFF_CTRL0     8'h00
`define STC_OFF_CTRL1     8'h04
`define STC_OFF_CNT_LO    8'h08
`define STC_OFF_CNT_HI    8'h0c
`define STC_OFF_CMPA_LO   8'h10
`define STC_OFF_CMPA_HI   8'h14
`define STC_OFF_FLAGS     8'h18
`define STC_RST_CTRL      8'h00
`define STC_RST_CMPA      10'h000
`define STC_RST_FLAGS     2'h0
`define STC_FLAG_A        0
`define STC_FLAG_P        1
`define STC_DIV4_MASK     6'h03
`define STC_DIV16_MASK    6'h0f
`define STC_DIV64_MASK    6'h3f
`define STC_PERIOD_STEP   7
`endif

// ===== stc_pkg.sv
package stc_pkg;
  typedef enum logic [1:0] {
    STC_MODE_CMP = 2'h0,
    STC_MODE_CAP = 2'h1,
    STC_MODE_PWM = 2'h2,
    STC_MODE_TC  = 2'h3
  } stc_mode_t;
  typedef enum logic [2:0] {
    STC_CK_SYS4 = 3'h0,
    STC_CK_SYS  = 3'h1,
    STC_CK_H16  = 3'h2,
    STC_CK_H64  = 3'h3,
    STC_CK_TBC  = 3'h4,
    STC_CK_NONE = 3'h5,
    STC_CK_EXTR = 3'h6,
    STC_CK_EXTF = 3'h7
  } stc_clk_sel_t;
  typedef struct packed {
    logic         pause_bit;
    stc_clk_sel_t clock_select_field;
    logic         counter_on_bit;
    logic [2:0]   period_match_field;
  } stc_ctrl0_t;
  typedef struct packed {
    stc_mode_t  mode_select_field;
    logic [1:0] pin_function_field;
    logic       initial_level_bit;
    logic       pin_invert_bit;
    logic       period_duty_swap_bit;
    logic       clear_select_bit;
  } stc_ctrl1_t;
endpackage : stc_pkg

// ===== stc_timer.sv
`timescale 1ns/1ns
`include "stc_consts.svh"
module stc_timer
  import stc_pkg::*;
#(
  parameter int CNT_W  = 10,
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Clock sources
  input  wire logic              timebase_tick,
  input  wire logic              timer_ext_clock_pin,
  // Timer pins
  input  wire logic              timer_pin_0_in,
  input  wire logic              timer_pin_1_in,
  output logic                   timer_out_pin_0,
  output logic                   timer_out_pin_0_oe_n,
  output logic                   timer_out_pin_1,
  output logic                   timer_out_pin_1_oe_n
);

  // ****************************************************
  // Register state
  // ****************************************************
  stc_ctrl0_t       ctrl0;
  stc_ctrl1_t       ctrl1;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] cmpa;
  logic [1:0]       flags;
  logic             on_prev;
  logic [5:0]       div_cnt;
  logic             ext_prev;
  logic             pin0_prev;
  logic             pin1_prev;
  logic             level;

  // ****************************************************
  // APB decode
  // ****************************************************
  wire logic [7:0] addr_lo   = paddr[7:0];
  wire logic       addr_hi0  = (paddr[ADDR_W-1:8] == '0);
  wire logic       hit_c0    = addr_hi0 && (addr_lo == `STC_OFF_CTRL0);
  wire logic       hit_c1    = addr_hi0 && (addr_lo == `STC_OFF_CTRL1);
  wire logic       hit_dl    = addr_hi0 && (addr_lo == `STC_OFF_CNT_LO);
  wire logic       hit_dh    = addr_hi0 && (addr_lo == `STC_OFF_CNT_HI);
  wire logic       hit_al    = addr_hi0 && (addr_lo == `STC_OFF_CMPA_LO);
  wire logic       hit_ah    = addr_hi0 && (addr_lo == `STC_OFF_CMPA_HI);
  wire logic       hit_fl    = addr_hi0 && (addr_lo == `STC_OFF_FLAGS);
  wire logic       hit_any   = hit_c0 | hit_c1 | hit_dl | hit_dh | hit_al | hit_ah | hit_fl;
  wire logic       setup_ph  = psel && !penable;
  wire logic       wr_acc    = psel && penable && pready && pwrite;
  wire logic       wr_c0     = wr_acc && hit_c0;
  wire logic       wr_c1     = wr_acc && hit_c1;
  wire logic       wr_al     = wr_acc && hit_al;
  wire logic       wr_ah     = wr_acc && hit_ah;
  wire logic       wr_fl     = wr_acc && hit_fl;

  // Counter is read only, upper bits of the high byte read zero
  wire logic [31:0] rd_dl = {24'h000000, cnt[7:0]};
  wire logic [31:0] rd_dh = {{(32-CNT_W+8){1'b0}}, cnt[CNT_W-1:8]};
  wire logic [31:0] rd_al = {24'h000000, cmpa[7:0]};
  wire logic [31:0] rd_ah = {{(32-CNT_W+8){1'b0}}, cmpa[CNT_W-1:8]};
  wire logic [31:0] rd_data =
      hit_c0 ? {24'h000000, ctrl0} :
      hit_c1 ? {24'h000000, ctrl1} :
      hit_dl ? rd_dl :
      hit_dh ? rd_dh :
      hit_al ? rd_al :
      hit_ah ? rd_ah :
      hit_fl ? {30'h00000000, flags} : 32'h00000000;

  // ****************************************************
  // Mode decode
  // ****************************************************
  wire stc_mode_t  mode     = ctrl1.mode_select_field;
  wire logic [1:0] pf       = ctrl1.pin_function_field;
  wire logic       m_cmp    = (mode == STC_MODE_CMP);
  wire logic       m_cap    = (mode == STC_MODE_CAP);
  wire logic       m_pwm    = (mode == STC_MODE_PWM);
  wire logic       m_tc     = (mode == STC_MODE_TC);
  wire logic       m_cmptc  = m_cmp | m_tc;
  wire logic       m_single = m_pwm && (pf == 2'h3);
  wire logic       on_rise  = ctrl0.counter_on_bit && !on_prev;

  // ****************************************************
  // Counting clock selection
  // ****************************************************
  // Both system and high clock run from pclk here, so one divider serves all
  wire logic tick4   = ((div_cnt & `STC_DIV4_MASK) == `STC_DIV4_MASK);
  wire logic tick16  = ((div_cnt & `STC_DIV16_MASK) == `STC_DIV16_MASK);
  wire logic tick64  = ((div_cnt & `STC_DIV64_MASK) == `STC_DIV64_MASK);
  wire logic ext_r   = timer_ext_clock_pin && !ext_prev;
  wire logic ext_f   = !timer_ext_clock_pin && ext_prev;
  logic      tck;

  always_comb begin
    case (ctrl0.clock_select_field)
      STC_CK_SYS4: tck = tick4;
      STC_CK_SYS:  tck = 1'b1;
      STC_CK_H16:  tck = tick16;
      STC_CK_H64:  tck = tick64;
      STC_CK_TBC:  tck = timebase_tick;
      STC_CK_EXTR: tck = ext_r;
      STC_CK_EXTF: tck = ext_f;
      default:     tck = 1'b0;
    endcase
  end

  // Off or paused holds the count where it stands
  wire logic run_tick = tck && ctrl0.counter_on_bit && !ctrl0.pause_bit;

  // ****************************************************
  // Comparators
  // ****************************************************
  wire logic [CNT_W:0]   inc_w    = {1'b0, cnt} + {{CNT_W{1'b0}}, 1'b1};
  wire logic [CNT_W-1:0] inc      = inc_w[CNT_W-1:0];
  wire logic [2:0]       per      = ctrl0.period_match_field;
  wire logic             overflow = inc_w[CNT_W];
  wire logic             p_top    = (inc[CNT_W-1 -: 3] == per) &&
                                    (inc[CNT_W-4:0] == '0);
  wire logic             p_hit    = (per == 3'h0) ? overflow : p_top;
  wire logic             a_hit    = (inc == cmpa);

  // Period or duty threshold built from the 3-bit field, 000 meaning full range
  wire logic [CNT_W:0]   p_span   = {(per == 3'h0), per, {`STC_PERIOD_STEP{1'b0}}};
  wire logic [CNT_W:0]   duty_val = ctrl1.period_duty_swap_bit ? p_span : {1'b0, cmpa};
  wire logic             pwm_act  = ({1'b0, cnt} < duty_val);

  logic clear_now;

  always_comb begin
    case (mode)
      STC_MODE_CMP,
      STC_MODE_TC:  clear_now = ctrl1.clear_select_bit ? a_hit : p_hit;
      STC_MODE_CAP: clear_now = p_hit;
      STC_MODE_PWM: begin
        if (m_single) begin
          clear_now = 1'b0;
        end else begin
          clear_now = ctrl1.period_duty_swap_bit ? a_hit : p_hit;
        end
      end
      default:      clear_now = 1'b0;
    endcase
  end

  wire logic [CNT_W-1:0] next_cnt = clear_now ? '0 : inc;

  // ****************************************************
  // Capture edges
  // ****************************************************
  wire logic rise_any = (timer_pin_0_in && !pin0_prev) || (timer_pin_1_in && !pin1_prev);
  wire logic fall_any = (!timer_pin_0_in && pin0_prev) || (!timer_pin_1_in && pin1_prev);
  logic      cap_edge;

  always_comb begin
    case (pf)
      2'h0:    cap_edge = rise_any;
      2'h1:    cap_edge = fall_any;
      2'h2:    cap_edge = rise_any | fall_any;
      default: cap_edge = 1'b0;
    endcase
  end

  wire logic cap_evt = m_cap && ctrl0.counter_on_bit && cap_edge;

  // ****************************************************
  // Flag events
  // ****************************************************
  // Clear select 1 in compare or timer mode suppresses the P flag entirely
  wire logic set_a = (run_tick && a_hit && !m_cap) || cap_evt;
  wire logic set_p = run_tick && p_hit && !m_single &&
                     !(m_cmptc && ctrl1.clear_select_bit);
  wire logic [1:0] set_vec = {set_p, set_a};
  wire logic [1:0] clr_vec = wr_fl ? pwdata[1:0] : 2'h0;
  // Set wins over a write-one clear in the same cycle
  wire logic [1:0] next_flags = (flags & ~clr_vec) | set_vec;

  // ****************************************************
  // Output level
  // ****************************************************
  wire logic init_lv = ctrl1.initial_level_bit;
  logic      next_level;

  always_comb begin
    next_level = level;
    if (m_cmp) begin
      if (on_rise) begin
        next_level = init_lv;
      end else if (run_tick && a_hit) begin
        case (pf)
          2'h1:    next_level = init_lv ? 1'b0 : level;
          2'h2:    next_level = init_lv ? level : 1'b1;
          2'h3:    next_level = !level;
          default: next_level = level;
        endcase
      end
    end else if (m_pwm) begin
      case (pf)
        2'h0:    next_level = !init_lv;
        2'h1:    next_level = init_lv;
        2'h2:    next_level = pwm_act ? init_lv : !init_lv;
        default: next_level = ctrl0.counter_on_bit ? init_lv : !init_lv;
      endcase
    end
  end

  // Timer and capture modes leave the pins free for other users
  wire logic drive_en  = m_cmp | m_pwm;
  wire logic next_pin  = next_level ^ ctrl1.pin_invert_bit;

  // ****************************************************
  // APB response
  // ****************************************************
  // One access cycle, no wait states: answer is prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph && !hit_any;
      if (setup_ph) begin
        prdata <= pwrite ? 32'h00000000 : rd_data;
      end
    end
  end

  // ****************************************************
  // Control registers
  // ****************************************************
  // Single pulse: pin edge starts the pulse, A match ends it
  wire logic sp_start = m_single && ext_r;
  wire logic sp_stop  = m_single && run_tick && a_hit;
  wire logic next_on  = sp_stop ? 1'b0 : (sp_start ? 1'b1 : ctrl0.counter_on_bit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0 <= stc_ctrl0_t'(`STC_RST_CTRL);
    end else if (wr_c0) begin
      ctrl0 <= stc_ctrl0_t'(pwdata[7:0]);
    end else begin
      ctrl0.counter_on_bit <= next_on;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1 <= stc_ctrl1_t'(`STC_RST_CTRL);
    end else if (wr_c1) begin
      ctrl1 <= stc_ctrl1_t'(pwdata[7:0]);
    end
  end

  // Compare A: software bytes, or the count when a capture edge arrives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmpa <= `STC_RST_CMPA;
    end else if (cap_evt) begin
      cmpa <= cnt;
    end else if (wr_al) begin
      cmpa[7:0] <= pwdata[7:0];
    end else if (wr_ah) begin
      cmpa[CNT_W-1:8] <= pwdata[CNT_W-9:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= `STC_RST_FLAGS;
    end else begin
      flags <= next_flags;
    end
  end

  // ****************************************************
  // Counter and edge history
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else if (on_rise) begin
      cnt <= '0;
    end else if (run_tick) begin
      cnt <= next_cnt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_prev   <= 1'b0;
      div_cnt   <= 6'h00;
      ext_prev  <= 1'b0;
      pin0_prev <= 1'b0;
      pin1_prev <= 1'b0;
    end else begin
      on_prev   <= ctrl0.counter_on_bit;
      div_cnt   <= div_cnt + 6'h01;
      ext_prev  <= timer_ext_clock_pin;
      pin0_prev <= timer_pin_0_in;
      pin1_prev <= timer_pin_1_in;
    end
  end

  // ****************************************************
  // Pin outputs
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level                <= 1'b0;
      timer_out_pin_0      <= 1'b0;
      timer_out_pin_1      <= 1'b0;
      timer_out_pin_0_oe_n <= 1'b1;
      timer_out_pin_1_oe_n <= 1'b1;
    end else begin
      level                <= next_level;
      timer_out_pin_0      <= next_pin;
      timer_out_pin_1      <= next_pin;
      timer_out_pin_0_oe_n <= !drive_en;
      timer_out_pin_1_oe_n <= !drive_en;
    end
  end

endmodule : stc_timer

// ===== stc_timer_properties.sv
`timescale 1ns/1ns
`include "stc_consts.svh"
module stc_timer_properties
  import stc_pkg::*;
#(
  parameter int CNT_W  = 10,
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // APB slave
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Timer pins
  input wire logic              timer_out_pin_0,
  input wire logic              timer_out_pin_0_oe_n,
  input wire logic              timer_out_pin_1_oe_n
);
  // ****************
  // Control shadow
  // ****************
  logic [7:0] sh_ctrl1;
  logic       sh_on;
  wire        wr_done = psel && penable && pready && pwrite;
  wire        rd_done = psel && penable && pready && !pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_ctrl1 <= 8'h00;
      sh_on    <= 1'b0;
    end else begin
      if (wr_done && paddr == `STC_OFF_CTRL1) sh_ctrl1 <= pwdata[7:0];
      if (wr_done && paddr == `STC_OFF_CTRL0) sh_on <= pwdata[3];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Only a real off-to-on edge restores the level; a rewrite with on set does not
  sequence on_rise_cmp;
    wr_done && paddr == `STC_OFF_CTRL0 && pwdata[3] && !sh_on && sh_ctrl1[7:6] == STC_MODE_CMP;
  endsequence
  sequence mode_held(logic [1:0] m);
    (sh_ctrl1[7:6] == m) [*3];
  endsequence
  // ****************
  // Properties
  // ****************
  ready_zero_wait_a: assert property (psel && !penable |=> pready) else $error("pready late");
  ready_single_a: assert property (pready |-> psel && penable ##1 !pready) else $error("pready misplaced");
  err_decode_a: assert property (psel && penable && pready |-> pslverr == !(paddr inside {`STC_OFF_CTRL0,
    `STC_OFF_CTRL1, `STC_OFF_CNT_LO, `STC_OFF_CNT_HI, `STC_OFF_CMPA_LO, `STC_OFF_CMPA_HI, `STC_OFF_FLAGS}))
    else $error("pslverr wrong");
  cnt_high_zero_a: assert property (rd_done && paddr == `STC_OFF_CNT_HI |-> prdata[31:2] == 30'h0)
    else $error("counter high bits");
  cmpa_high_zero_a: assert property (rd_done && paddr == `STC_OFF_CMPA_HI |-> prdata[31:2] == 30'h0)
    else $error("compare high bits");
  timer_no_drive_a: assert property (mode_held(STC_MODE_TC) |-> timer_out_pin_0_oe_n && timer_out_pin_1_oe_n)
    else $error("timer mode drives pin");
  cmp_drive_a: assert property (mode_held(STC_MODE_CMP) |-> !timer_out_pin_0_oe_n)
    else $error("compare mode pin idle");
  restart_level_a: assert property (on_rise_cmp |-> ##[1:3] timer_out_pin_0 == (sh_ctrl1[3] ^ sh_ctrl1[2]))
    else $error("restart level wrong");
endmodule : stc_timer_properties

// ===== stc_far_side.sv
`timescale 1ns/1ns
module stc_far_side (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin seen from outside
  input  wire logic pin_0,
  input  wire logic pin_0_oe_n,
  // Towards the timer, plus the pad level as the testbench sees it
  output logic      timebase_tick,
  output logic      ext_clock,
  output logic      cap_0,
  output logic      cap_1,
  output logic      pad_0
);
  logic [3:0] div;
  logic       last_0;
  initial ext_clock = 1'b0;
  initial cap_0 = 1'b0;
  assign cap_1 = 1'b0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div    <= 4'h0;
      last_0 <= 1'b0;
    end else begin
      div <= div + 4'h1;
      if (!pin_0_oe_n) last_0 <= pin_0;
    end
  end
  assign timebase_tick = (div == 4'hf);
  // No pull on the pad, so a released pad must not pass for the last level
  assign pad_0 = pin_0_oe_n ? ~last_0 : pin_0;
  // External clock stands low between bursts
  task automatic pulses(input int n);
    repeat (n) begin
      ext_clock <= 1'b1;
      repeat (2) @(posedge pclk);
      ext_clock <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask : pulses
  // Capture pin is a plain level, moved just after a clock edge
  task automatic cap_level(input logic lv);
    cap_0 <= lv;
  endtask : cap_level
endmodule : stc_far_side

// ===== tb.sv
`timescale 1ns/1ns
`include "stc_consts.svh"
module tb;
  import stc_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, tick, ext, cap0, cap1, out0, oe0_n, out1, oe1_n, pad0;
  int          bad_count, compares;
  stc_timer i_stc_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timebase_tick(tick),
    .timer_ext_clock_pin(ext), .timer_pin_0_in(cap0), .timer_pin_1_in(cap1), .timer_out_pin_0(out0),
    .timer_out_pin_0_oe_n(oe0_n), .timer_out_pin_1(out1), .timer_out_pin_1_oe_n(oe1_n));
  stc_far_side i_stc_far_side (.pclk(pclk), .presetn(presetn), .pin_0(out0), .pin_0_oe_n(oe0_n),
    .timebase_tick(tick), .ext_clock(ext), .cap_0(cap0), .cap_1(cap1), .pad_0(pad0));
  always #2 pclk = ~pclk;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic test_done;
    if (bad_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  // ****************
  // APB master
  // ****************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {4'h0, a};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Request stands until the edge that samples pready high; data taken there
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20) check("pready", 32'h0, 32'h1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask : rchk
  // ****************
  // Scenarios
  // ****************
  task automatic t_regs;
    for (int i = 0; i < 7; i++) rchk("reset", 8'(i * 4), 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    check("unmapped_err", 32'(err), 32'h1);
    check("unmapped_rd", rd, 32'h0);
    apb(1'b1, `STC_OFF_CNT_LO, 32'hff);
    rchk("cnt_ro", `STC_OFF_CNT_LO, 32'h0);
    apb(1'b1, `STC_OFF_CMPA_LO, 32'h1ab);
    apb(1'b1, `STC_OFF_CMPA_HI, 32'hff);
    rchk("cmpa_lo", `STC_OFF_CMPA_LO, 32'hab);
    rchk("cmpa_hi", `STC_OFF_CMPA_HI, 32'h3);
  endtask : t_regs
  task automatic t_pins;
    logic exp;
    apb(1'b1, `STC_OFF_CMPA_LO, 32'h64);
    apb(1'b1, `STC_OFF_CMPA_HI, 32'h0);
    for (int f = 0; f < 8; f++) begin
      exp = (f[2:1] == 0) ? f[0] : (f[2:1] == 1) ? 1'b0 : (f[2:1] == 2) ? 1'b1 : ~f[0];
      apb(1'b1, `STC_OFF_CTRL0, 32'h11);
      apb(1'b1, `STC_OFF_FLAGS, 32'h3);
      apb(1'b1, `STC_OFF_CTRL1, {26'h0, f[2:0], 3'h0});
      apb(1'b1, `STC_OFF_CTRL0, 32'h19);
      repeat (5) @(posedge pclk);
      check("pin_init", 32'(out0), 32'(f[0]));
      repeat (100) @(posedge pclk);
      check("pin_match", 32'(out0), 32'(exp));
      rchk("flag_a", `STC_OFF_FLAGS, 32'h1);
      repeat (30) @(posedge pclk);
      check("pin_p", 32'(out0), 32'(exp));
      rchk("flag_ap", `STC_OFF_FLAGS, 32'h3);
      apb(1'b1, `STC_OFF_CTRL0, 32'h11);
      apb(1'b0, `STC_OFF_CNT_LO, 32'h0);
      check("cnt_wrap", 32'(rd < 128), 32'h1);
    end
  endtask : t_pins
  task automatic t_clear_a;
    apb(1'b1, `STC_OFF_CMPA_LO, 32'h3);
    apb(1'b1, `STC_OFF_FLAGS, 32'h3);
    apb(1'b1, `STC_OFF_CTRL1, 32'h21);
    apb(1'b1, `STC_OFF_CTRL0, 32'h19);
    repeat (300) @(posedge pclk);
    rchk("flag_a_only", `STC_OFF_FLAGS, 32'h1);
    apb(1'b1, `STC_OFF_CTRL0, 32'h11);
    apb(1'b0, `STC_OFF_CNT_LO, 32'h0);
    check("cnt_a_clear", 32'(rd < 3), 32'h1);
  endtask : t_clear_a
  task automatic t_invert;
    apb(1'b1, `STC_OFF_CTRL1, 32'h04);
    apb(1'b1, `STC_OFF_CTRL0, 32'h19);
    repeat (5) @(posedge pclk);
    check("pin_inv", 32'({oe0_n, pad0}), 32'h1);
    check("pin1_inv", 32'({oe1_n, out1}), 32'h1);
    apb(1'b1, `STC_OFF_CTRL0, 32'h11);
    apb(1'b1, `STC_OFF_FLAGS, 32'h3);
    apb(1'b1, `STC_OFF_CTRL1, 32'hc0);
    apb(1'b1, `STC_OFF_CTRL0, 32'h19);
    repeat (140) @(posedge pclk);
    check("tc_oe_n", 32'({oe0_n, oe1_n}), 32'h3);
    rchk("tc_flags", `STC_OFF_FLAGS, 32'h3);
  endtask : t_invert
  task automatic t_count;
    logic [31:0] held;
    int          n;
    for (int s = 0; s < 8; s++) begin
      if (s != 1) begin
        apb(1'b1, `STC_OFF_CTRL0, 32'(s << 4));
        apb(1'b1, `STC_OFF_CTRL0, 32'((s << 4) | 8));
        if (s < 5) begin
          // Divider phase is free running, so allow one tick either way
          repeat (128) @(posedge pclk);
          apb(1'b0, `STC_OFF_CNT_LO, 32'h0);
          n = 128 / ((s == 0) ? 4 : (s == 3) ? 64 : 16);
          check("clk_rate", 32'(rd + 1 >= n && rd <= n + 1), 32'h1);
        end else begin
          i_stc_far_side.pulses(5);
          repeat (3) @(posedge pclk);
          rchk("ext_count", `STC_OFF_CNT_LO, (s == 5) ? 32'h0 : 32'h5);
        end
      end
    end
    apb(1'b1, `STC_OFF_CTRL0, 32'h10);
    apb(1'b1, `STC_OFF_FLAGS, 32'h3);
    apb(1'b1, `STC_OFF_CTRL0, 32'h18);
    repeat (20) @(posedge pclk);
    apb(1'b1, `STC_OFF_CTRL0, 32'h98);
    apb(1'b0, `STC_OFF_CNT_LO, 32'h0);
    held = rd;
    repeat (20) @(posedge pclk);
    rchk("paused", `STC_OFF_CNT_LO, held);
    apb(1'b1, `STC_OFF_CTRL0, 32'h18);
    repeat (600) @(posedge pclk);
    apb(1'b0, `STC_OFF_CNT_HI, 32'h0);
    check("cnt_high", 32'(rd != 0 && rd < 4), 32'h1);
    repeat (500) @(posedge pclk);
    rchk("overflow", `STC_OFF_FLAGS, 32'h3);
    apb(1'b1, `STC_OFF_CTRL0, 32'h10);
    apb(1'b0, `STC_OFF_CNT_LO, 32'h0);
    held = rd;
    repeat (20) @(posedge pclk);
    rchk("off_hold", `STC_OFF_CNT_LO, held);
    apb(1'b1, `STC_OFF_CTRL0, 32'h18);
    apb(1'b1, `STC_OFF_CTRL0, 32'h10);
    apb(1'b0, `STC_OFF_CNT_LO, 32'h0);
    check("restart", 32'(rd < 8), 32'h1);
  endtask : t_count
  task automatic t_cap_pwm;
    apb(1'b1, `STC_OFF_CTRL0, 32'h10);
    apb(1'b1, `STC_OFF_FLAGS, 32'h3);
    apb(1'b1, `STC_OFF_CTRL1, 32'h40);
    apb(1'b1, `STC_OFF_CTRL0, 32'h18);
    repeat (40) @(posedge pclk);
    i_stc_far_side.cap_level(1'b1);
    @(posedge pclk);
    rchk("cap_value", `STC_OFF_CMPA_LO, 32'h28);
    rchk("cap_flag", `STC_OFF_FLAGS, 32'h1);
    i_stc_far_side.cap_level(1'b0);
    apb(1'b1, `STC_OFF_CTRL0, 32'h10);
    apb(1'b1, `STC_OFF_FLAGS, 32'h3);
    apb(1'b1, `STC_OFF_CTRL1, 32'h70);
    apb(1'b1, `STC_OFF_CTRL0, 32'h18);
    i_stc_far_side.cap_level(1'b1);
    repeat (3) @(posedge pclk);
    i_stc_far_side.cap_level(1'b0);
    rchk("cap_off", `STC_OFF_FLAGS, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `STC_OFF_CTRL0, 32'h11);
      apb(1'b1, `STC_OFF_CTRL1, 32'(8'h80 | (i << 3)));
      apb(1'b1, `STC_OFF_CTRL0, 32'h19);
      repeat (3) @(posedge pclk);
      check("pwm_force", 32'({oe0_n, out0}), 32'(i[1] ? i[0] : !i[0]));
    end
    apb(1'b1, `STC_OFF_CTRL0, 32'h11);
    apb(1'b1, `STC_OFF_CTRL1, 32'ha8);
    apb(1'b1, `STC_OFF_CTRL0, 32'h19);
    repeat (10) @(posedge pclk);
    check("pwm_active", 32'(out0), 32'h1);
    repeat (50) @(posedge pclk);
    check("pwm_idle", 32'(out0), 32'h0);
    apb(1'b1, `STC_OFF_CTRL0, 32'h11);
  endtask : t_cap_pwm
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_pins();
    t_clear_a();
    t_invert();
    t_count();
    t_cap_pwm();
    test_done();
  end
  // Whole run is some 3900 cycles; allow about five times that
  initial begin
    #80000;
    bad_count++;
    test_done();
  end
endmodule : tb
bind stc_timer stc_timer_properties #(.CNT_W(CNT_W), .ADDR_W(ADDR_W)) i_stc_timer_properties (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_out_pin_0(timer_out_pin_0),
  .timer_out_pin_0_oe_n(timer_out_pin_0_oe_n), .timer_out_pin_1_oe_n(timer_out_pin_1_oe_n));
